/* File: common/light_pkg.sv */
// Package for the ambient-light settings and result block.
// Assumes one 200 MHz clock; holds register offsets, field positions,
// reset values, the rate table and the sequencer states.
package light_pkg;

   // Register offsets as seen by the serial register port
   localparam logic [7:0] ADDR_SETTINGS   = 8'h84;
   localparam logic [7:0] ADDR_RESULT_HI  = 8'h85;
   localparam logic [7:0] ADDR_RESULT_LO  = 8'h86;

   // Settings field positions
   localparam int CONT_BIT    = 7;
   localparam int RATE_HI     = 6;
   localparam int RATE_LO     = 4;
   localparam int COMP_BIT    = 3;
   localparam int AVG_HI      = 2;
   localparam int AVG_LO      = 0;

   // Continuous off, rate code 001, offset compensation on, one conversion
   localparam logic [7:0] SETTINGS_RESET = 8'h18;
   localparam logic [7:0] RDATA_UNMAPPED = 8'h00;

   // Clock rate; the sample period in cycles is this divided by samples/s
   localparam int CLK_RATE_HZ = 200_000_000;

   // Widths of the result, accumulator and conversion counter
   localparam int RESULT_W = 16;
   localparam int ACC_W    = 23;
   localparam int CNT_W    = 8;

   // Samples per second for each rate code
   function automatic int rate_sps(input logic [2:0] code);
      case (code)
         3'h0:    rate_sps = 1;
         3'h1:    rate_sps = 2;
         3'h2:    rate_sps = 3;
         3'h3:    rate_sps = 4;
         3'h4:    rate_sps = 5;
         3'h5:    rate_sps = 6;
         3'h6:    rate_sps = 8;
         default: rate_sps = 10;
      endcase
   endfunction : rate_sps

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_OFS_GO,
      ST_OFS_WAIT,
      ST_MEAS_GO,
      ST_MEAS_WAIT,
      ST_FINISH
   } seq_state_t;

endpackage : light_pkg

/* File: hw/tick_divider.sv */
// Rate divider: one-cycle tick every period_in cycles while enabled.
// Assumes period_in is at least one and changes only between runs.
`timescale 1ns/1ps
`default_nettype none
module tick_divider #(
   parameter int W = 32
) (
   input  wire logic         ref_clk_in,
   input  wire logic         arst_n_in,
   input  wire logic         enable_in,
   input  wire logic [W-1:0] period_in,
   output logic              tick_out
);

   typedef struct packed {
      logic [W-1:0] cnt;
      logic         tick;
   } div_state_t;

   div_state_t s_q;
   div_state_t s_d;

   // Count up, wrap at period; disabled means restart from zero
   always_comb begin
      s_d      = s_q;
      s_d.tick = 1'b0;
      if (!enable_in) begin
         s_d.cnt = '0;
      end else if (s_q.cnt >= period_in - W'(1)) begin
         s_d.cnt  = '0;
         s_d.tick = 1'b1;
      end else begin
         s_d.cnt = s_q.cnt + W'(1);
      end
   end

   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end

   assign tick_out = s_q.tick;

endmodule : tick_divider
`default_nettype wire

/* File: hw/light_param_result.sv */
// Ambient-light settings register, measurement sequencer and result.
// Assumes a serial-bus front end outside drives the byte register port
// and an analog converter outside answers conv_start_out with one
// conv_done_in pulse carrying conv_data_in.
// How it works
// - Settings byte at 84h: continuous, rate, offset compensation, averaging.
// - Bit 7 enables continuous conversion; reset value zero.
// - Continuous mode restarts runs back to back instead of waiting.
// - Rate codes 000..101 give 1..6 samples/s, 111 gives 10.
// - Bit 3 enables offset compensation; reset value one.
// - With compensation, offset measured before each conversion and subtracted.
// - Writes during self-timed mode wait until that mode is cycled.
// - Sixteen-bit result in bytes 85h (high) and 86h (low).
// - High result byte is read-only, returns bits 15:8.
// - Low result byte is read-only, returns bits 7:0.
`timescale 1ns/1ps
`default_nettype none
module light_param_result #(
   parameter int CLK_HZ = light_pkg::CLK_RATE_HZ
) (
   input  wire logic        ref_clk_in,
   input  wire logic        arst_n_in,
   input  wire logic [7:0]  reg_addr_in,
   input  wire logic        reg_wr_in,
   input  wire logic [7:0]  reg_wdata_in,
   input  wire logic        reg_rd_in,
   output logic      [7:0]  reg_rdata_out,
   input  wire logic        selftimed_en_in,
   input  wire logic        light_enable_in,
   input  wire logic        light_single_shot_in,
   output logic             conv_start_out,
   output logic             conv_offset_out,
   input  wire logic        conv_done_in,
   input  wire logic [15:0] conv_data_in,
   output logic             busy_out
);

   typedef struct packed {
      logic [7:0]                      pend;
      logic [7:0]                      act;
      light_pkg::seq_state_t           state;
      logic [light_pkg::RESULT_W-1:0]  offs;
      logic [light_pkg::ACC_W-1:0]     acc;
      logic [light_pkg::CNT_W-1:0]     cnt;
      logic [light_pkg::RESULT_W-1:0]  result;
      logic [7:0]                      rdata;
      logic                            start;
      logic                            ofs_flag;
      logic                            offs_done;
      logic                            busy;
   } top_state_t;

   top_state_t s_q;
   top_state_t s_d;

   logic        tick;
   logic        timed_run;
   logic [31:0] period;
   logic [light_pkg::CNT_W-1:0]    target;
   logic [light_pkg::RESULT_W-1:0] sample;

   assign timed_run = selftimed_en_in && light_enable_in;

   // Sample period in cycles from the active rate code
   assign period = 32'(CLK_HZ / light_pkg::rate_sps(
                   s_q.act[light_pkg::RATE_HI:light_pkg::RATE_LO]));

   // Conversions per run is a power of two
   assign target = light_pkg::CNT_W'(1) <<
                   s_q.act[light_pkg::AVG_HI:light_pkg::AVG_LO];

   // Clamp at zero so a noisy offset never wraps the reading
   assign sample = !s_q.act[light_pkg::COMP_BIT] ? conv_data_in :
                   (conv_data_in > s_q.offs) ? conv_data_in - s_q.offs :
                   '0;

   tick_divider #(
      .W (32)
   ) u_rate (
      .ref_clk_in (ref_clk_in),
      .arst_n_in  (arst_n_in),
      .enable_in  (timed_run),
      .period_in  (period),
      .tick_out   (tick)
   );

   // Register port, settings hand-over and measurement sequencer
   always_comb begin
      s_d          = s_q;
      s_d.start    = 1'b0;
      s_d.ofs_flag = 1'b0;

      // Only the settings byte is writable; result bytes ignore writes
      if (reg_wr_in && reg_addr_in == light_pkg::ADDR_SETTINGS) begin
         s_d.pend = reg_wdata_in;
      end
      // Pending value reaches the sequencer only outside self-timed mode
      if (!selftimed_en_in) begin
         s_d.act = s_d.pend;
      end

      // Read data registered one cycle after the strobe
      if (reg_rd_in) begin
         case (reg_addr_in)
            light_pkg::ADDR_SETTINGS:  s_d.rdata = s_q.pend;
            light_pkg::ADDR_RESULT_HI: s_d.rdata = s_q.result[15:8];
            light_pkg::ADDR_RESULT_LO: s_d.rdata = s_q.result[7:0];
            default:                   s_d.rdata = light_pkg::RDATA_UNMAPPED;
         endcase
      end

      case (s_q.state)
         light_pkg::ST_IDLE: begin
            // Ticks arriving mid-run are dropped, runs never overlap
            if ((timed_run && tick) ||
                (!selftimed_en_in && light_single_shot_in)) begin
               s_d.acc   = '0;
               s_d.cnt   = '0;
               s_d.busy  = 1'b1;
               s_d.state = s_q.act[light_pkg::COMP_BIT] ?
                           light_pkg::ST_OFS_GO : light_pkg::ST_MEAS_GO;
            end
         end
         light_pkg::ST_OFS_GO: begin
            s_d.start     = 1'b1;
            s_d.ofs_flag  = 1'b1;
            s_d.offs_done = 1'b0;
            s_d.state     = light_pkg::ST_OFS_WAIT;
         end
         light_pkg::ST_OFS_WAIT: begin
            if (conv_done_in) begin
               s_d.offs      = conv_data_in;
               s_d.offs_done = 1'b1;
               s_d.state     = light_pkg::ST_MEAS_GO;
            end
         end
         light_pkg::ST_MEAS_GO: begin
            s_d.start = 1'b1;
            s_d.state = light_pkg::ST_MEAS_WAIT;
         end
         light_pkg::ST_MEAS_WAIT: begin
            if (conv_done_in) begin
               s_d.acc       = s_q.acc + light_pkg::ACC_W'(sample);
               s_d.cnt       = s_q.cnt + light_pkg::CNT_W'(1);
               s_d.offs_done = 1'b0;
               if (s_q.cnt + light_pkg::CNT_W'(1) >= target) begin
                  s_d.state = light_pkg::ST_FINISH;
               end else begin
                  s_d.state = s_q.act[light_pkg::COMP_BIT] ?
                              light_pkg::ST_OFS_GO : light_pkg::ST_MEAS_GO;
               end
            end
         end
         light_pkg::ST_FINISH: begin
            // Shift divides exactly since the count is a power of two
            s_d.result = light_pkg::RESULT_W'(s_q.acc >>
                         s_q.act[light_pkg::AVG_HI:light_pkg::AVG_LO]);
            s_d.acc    = '0;
            s_d.cnt    = '0;
            // Continuous mode skips the rate wait
            if (timed_run && s_q.act[light_pkg::CONT_BIT]) begin
               s_d.state = s_q.act[light_pkg::COMP_BIT] ?
                           light_pkg::ST_OFS_GO : light_pkg::ST_MEAS_GO;
            end else begin
               s_d.busy  = 1'b0;
               s_d.state = light_pkg::ST_IDLE;
            end
         end
         default: begin
            s_d.busy  = 1'b0;
            s_d.state = light_pkg::ST_IDLE;
         end
      endcase
   end

   // Single state register
   always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         s_q       <= '0;
         s_q.pend  <= light_pkg::SETTINGS_RESET;
         s_q.act   <= light_pkg::SETTINGS_RESET;
         s_q.state <= light_pkg::ST_IDLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign reg_rdata_out   = s_q.rdata;
   assign conv_start_out  = s_q.start;
   assign conv_offset_out = s_q.ofs_flag;
   assign busy_out        = s_q.busy;

   // Checks
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!arst_n_in);

   sequence rd_hi_s;
      reg_rd_in && reg_addr_in == light_pkg::ADDR_RESULT_HI;
   endsequence
   sequence rd_lo_s;
      reg_rd_in && reg_addr_in == light_pkg::ADDR_RESULT_LO;
   endsequence

   result_high_a: assert property (rd_hi_s |=>
      reg_rdata_out == $past(s_q.result[15:8]))
      else $error("high result byte read mismatch");
   result_low_a: assert property (rd_lo_s |=>
      reg_rdata_out == $past(s_q.result[7:0]))
      else $error("low result byte read mismatch");
   settings_read_a: assert property (
      reg_rd_in && reg_addr_in == light_pkg::ADDR_SETTINGS && !reg_wr_in
      |=> reg_rdata_out == $past(s_q.pend))
      else $error("settings read mismatch");
   result_ro_a: assert property (
      reg_wr_in && reg_addr_in != light_pkg::ADDR_SETTINGS &&
      s_q.state != light_pkg::ST_FINISH |=> $stable(s_q.result))
      else $error("result changed by a write");
   pending_hold_a: assert property (
      selftimed_en_in && $past(selftimed_en_in) |-> $stable(s_q.act))
      else $error("settings applied during self-timed mode");
   offset_first_a: assert property (
      conv_start_out && !conv_offset_out && s_q.act[light_pkg::COMP_BIT]
      |-> s_q.offs_done)
      else $error("conversion without a fresh offset");
   avg_count_a: assert property (
      s_q.state == light_pkg::ST_FINISH |-> s_q.cnt == target)
      else $error("wrong number of conversions in run");
   cont_restart_a: assert property (
      s_q.state == light_pkg::ST_FINISH && timed_run &&
      s_q.act[light_pkg::CONT_BIT] |-> ##[1:2] conv_start_out)
      else $error("continuous run did not restart");

endmodule : light_param_result
`default_nettype wire

/* File: test/conv_model.sv */
// Behavioural analog converter facing the light block.
// Assumes one clock; answers each start pulse lat_in plus one cycles after it is sampled.
`timescale 1ns/1ps
`default_nettype none
module conv_model (
   input  wire logic        clk_in,
   input  wire logic        arst_n_in,
   input  wire logic        start_in,
   input  wire logic        offset_in,
   input  wire logic [7:0]  lat_in,
   input  wire logic [15:0] raw_in,
   input  wire logic [15:0] ofs_in,
   output logic             done_out,
   output logic      [15:0] data_out
);
   logic [7:0]  cnt_q;
   logic        pend_q;
   logic [15:0] val_q;

   // Data toggles outside done, so nothing may lean on a stale value
   always_ff @(posedge clk_in or negedge arst_n_in) begin
      if (!arst_n_in) begin
         cnt_q    <= 8'h00;
         pend_q   <= 1'b0;
         val_q    <= 16'h0000;
         done_out <= 1'b0;
         data_out <= 16'hA5A5;
      end else begin
         done_out <= 1'b0;
         data_out <= ~data_out;
         if (start_in) begin
            pend_q <= 1'b1;
            cnt_q  <= lat_in;
            val_q  <= offset_in ? ofs_in : raw_in;
         end else if (pend_q && cnt_q == 8'h00) begin
            pend_q   <= 1'b0;
            done_out <= 1'b1;
            data_out <= val_q;
         end else if (pend_q) begin
            cnt_q <= cnt_q - 8'h01;
         end
      end
   end
endmodule : conv_model
`default_nettype wire

/* File: test/light_param_result_test.sv */
// Self-checking bench for the light settings and result block.
// Assumes a 1 kHz notional rate clock so sample periods stay short.
`timescale 1ns/1ps
`default_nettype none
module light_param_result_test;
   logic        clk = 1'b0;
   logic        arst_n = 1'b0;
   logic [7:0]  addr = 8'h00;
   logic        wr = 1'b0;
   logic [7:0]  wdata = 8'h00;
   logic        rd = 1'b0;
   logic [7:0]  rdata;
   logic        selftimed = 1'b0;
   logic        light_en = 1'b0;
   logic        single = 1'b0;
   logic        start;
   logic        offset;
   logic        done;
   logic        busy;
   logic [15:0] data;
   logic [15:0] raw = 16'h0000;
   logic [15:0] ofs = 16'h0000;
   logic [7:0]  lat = 8'h01;
   int          fails = 0;
   int          n_checks = 0;
   int          n_start = 0;
   int          n_ofs = 0;
   int          n;
   int          sps [8] = '{1, 2, 3, 4, 5, 6, 8, 10};

   always #2.5 clk = ~clk;

   light_param_result #(.CLK_HZ(1000)) dut_u (
      .ref_clk_in(clk), .arst_n_in(arst_n), .reg_addr_in(addr),
      .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd),
      .reg_rdata_out(rdata), .selftimed_en_in(selftimed),
      .light_enable_in(light_en), .light_single_shot_in(single),
      .conv_start_out(start), .conv_offset_out(offset),
      .conv_done_in(done), .conv_data_in(data), .busy_out(busy));

   conv_model conv_u (
      .clk_in(clk), .arst_n_in(arst_n), .start_in(start),
      .offset_in(offset), .lat_in(lat), .raw_in(raw), .ofs_in(ofs),
      .done_out(done), .data_out(data));

   // Count converter starts and the dark ones among them
   always @(posedge clk) begin
      if (start === 1'b1) begin
         n_start++;
         if (offset === 1'b1) n_ofs++;
      end
   end

   task automatic wrap_up;
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask : wrap_up

   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      n_checks++;
      if (seen !== exp) begin
         fails++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // Idle cycle after each strobe so no strobe is set twice in a step
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      addr = a;
      wdata = d;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
      @(negedge clk);
   endtask : wr_reg

   task automatic rd_reg(input logic [7:0] a, input logic [7:0] exp);
      addr = a;
      rd = 1'b1;
      @(negedge clk);
      rd = 1'b0;
      @(negedge clk);
      chk({8'h00, rdata}, {8'h00, exp});
   endtask : rd_reg

   task automatic wait_busy(input logic lvl);
      int i;
      for (i = 0; i < 5000 && busy !== lvl; i++) @(negedge clk);
      if (i == 5000) begin
         fails++;
         wrap_up();
      end
   endtask : wait_busy

   // Cycles from the next converter start to the one after it
   task automatic gap(output int cyc);
      int i;
      for (i = 0; i < 3000 && start !== 1'b1; i++) @(negedge clk);
      cyc = 0;
      do begin
         @(negedge clk);
         cyc++;
      end while (start !== 1'b1 && cyc < 3000);
      if (i == 3000 || cyc == 3000) begin
         fails++;
         wrap_up();
      end
   endtask : gap

   task automatic run_one(input logic [7:0] st, input logic [15:0] r,
                          input logic [15:0] o, input logic [15:0] res,
                          input int ns, input int no);
      raw = r;
      ofs = o;
      wr_reg(light_pkg::ADDR_SETTINGS, st);
      rd_reg(light_pkg::ADDR_SETTINGS, st);
      n_start = 0;
      n_ofs = 0;
      single = 1'b1;
      wait_busy(1'b1);
      single = 1'b0;
      wait_busy(1'b0);
      chk(n_start[15:0], ns[15:0]);
      chk(n_ofs[15:0], no[15:0]);
      wr_reg(light_pkg::ADDR_RESULT_HI, 8'hFF);
      wr_reg(light_pkg::ADDR_RESULT_LO, 8'hFF);
      rd_reg(light_pkg::ADDR_RESULT_HI, res[15:8]);
      rd_reg(light_pkg::ADDR_RESULT_LO, res[7:0]);
   endtask : run_one

   initial begin
      repeat (20) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      rd_reg(light_pkg::ADDR_SETTINGS, 8'h18);
      rd_reg(light_pkg::ADDR_RESULT_HI, 8'h00);
      rd_reg(8'h87, light_pkg::RDATA_UNMAPPED);
      // Slow converter first, then boundary averaging counts
      lat = 8'h1E;
      run_one(8'h09, 16'h1234, 16'h0034, 16'h1200, 4, 2);
      lat = 8'h01;
      run_one(8'h02, 16'h0155, 16'h0100, 16'h0155, 4, 0);
      run_one(8'h08, 16'h0010, 16'h0020, 16'h0000, 2, 1);
      run_one(8'h07, 16'hABCD, 16'h0000, 16'hABCD, 128, 0);
      // Every rate code; rates change only with self-timed off
      light_en = 1'b1;
      for (int c = 0; c < 8; c++) begin
         wr_reg(light_pkg::ADDR_SETTINGS, {1'b0, c[2:0], 4'h0});
         repeat (2) @(negedge clk);
         selftimed = 1'b1;
         gap(n);
         chk(n[15:0], 16'(1000 / sps[c]));
         selftimed = 1'b0;
         wait_busy(1'b0);
      end
      // Write while self-timed runs: held until the mode is cycled
      selftimed = 1'b1;
      gap(n);
      wr_reg(light_pkg::ADDR_SETTINGS, 8'h00);
      rd_reg(light_pkg::ADDR_SETTINGS, 8'h00);
      gap(n);
      gap(n);
      chk(n[15:0], 16'h0064);
      selftimed = 1'b0;
      wait_busy(1'b0);
      repeat (2) @(negedge clk);
      selftimed = 1'b1;
      gap(n);
      chk(n[15:0], 16'h03E8);
      selftimed = 1'b0;
      wait_busy(1'b0);
      // Continuous mode must beat the slowest rate by far
      wr_reg(light_pkg::ADDR_SETTINGS, 8'h80);
      rd_reg(light_pkg::ADDR_SETTINGS, 8'h80);
      selftimed = 1'b1;
      gap(n);
      gap(n);
      chk({15'h0000, n < 20}, 16'h0001);
      // Reset in mid-run brings back the defaults and clears the result
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      @(negedge clk);
      rd_reg(light_pkg::ADDR_SETTINGS, 8'h18);
      rd_reg(light_pkg::ADDR_RESULT_HI, 8'h00);
      rd_reg(light_pkg::ADDR_RESULT_LO, 8'h00);
      wrap_up();
   end
endmodule : light_param_result_test
`default_nettype wire
